// File: verilog/esdg_pkg.sv
// Purpose: Shared constants for the slot-side DMA burst glue and its board.
// Assumes: Link clock is made by the board end from its own clk.
// Notes: Byte enable codes are written {en3,en2,en1,en0}, active low.
package esdg_pkg;

  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int ADDR_W = 12;
  localparam int FIFO_W = DATA_W + BE_W;
  localparam int FIFO_DEPTH = 16;
  localparam int LEN_W = 8;

  // I/O base compared against address bits 15..4
  localparam logic [ADDR_W-1:0] IO_BASE_DEFAULT = 12'h030;

  localparam logic [BE_W-1:0] BE_DWORD = 4'h0;
  localparam logic [BE_W-1:0] BE_LOW_WORD = 4'hC;
  localparam logic [BE_W-1:0] BE_HIGH_WORD = 4'h3;
  localparam logic [BE_W-1:0] BE_BYTE0 = 4'hE;
  localparam logic [BE_W-1:0] BE_BYTE1 = 4'hD;
  localparam logic [BE_W-1:0] BE_BYTE2 = 4'hB;
  localparam logic [BE_W-1:0] BE_BYTE3 = 4'h7;
  localparam logic [BE_W-1:0] LANES_NONE = 4'h0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int BCLK_HALF_NS = 20;
  localparam int BCLK_HALF_CLKS = BCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 4;

  // Command phase length in half link-clock periods
  localparam logic [1:0] CMD_TICKS_NORMAL = 2'h2;
  localparam logic [1:0] CMD_TICKS_COMP = 2'h1;

  localparam logic [1:0] CMD_PROBE = 2'h0;
  localparam logic [1:0] CMD_DMA_WRITE = 2'h1;
  localparam logic [1:0] CMD_DMA_READ = 2'h2;

  // Unsupported enable patterns select no lane at all
  function automatic logic [BE_W-1:0] be_lanes(input logic [BE_W-1:0] be_n);
    case (be_n)
      BE_DWORD, BE_LOW_WORD, BE_HIGH_WORD, BE_BYTE0, BE_BYTE1, BE_BYTE2,
      BE_BYTE3: be_lanes = ~be_n;
      default: be_lanes = LANES_NONE;
    endcase
  endfunction

endpackage

// File: verilog/esdg_if.sv
// Purpose: Slot wiring between the glue device and the system board end.
// Assumes: Board drives host_side_clock; device samples on its rising edge.
// Notes: The shared data bus is resolved here from the two output enables.
interface esdg_if;
  import esdg_pkg::*;

  logic host_side_clock;
  logic [ADDR_W-1:0] io_address;
  logic addr_a1;
  logic aen;
  logic address_strobe_n;
  logic [BE_W-1:0] byte_enables_n;
  logic local_device_claim_n;
  logic nows_n;
  logic data_path_select_n;
  logic transfer_direction;
  logic cycle_strobe_n;
  logic ready_return_n;
  logic beat_hold;
  logic local_bus_mode_select_n;
  logic [DATA_W-1:0] board_data;
  logic board_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic [DATA_W-1:0] data_bus;

  // Undriven bus reads as zero
  assign data_bus = dev_data_oe ? dev_data :
                    (board_data_oe ? board_data : '0);

  modport device (
    input host_side_clock, io_address, addr_a1, aen, address_strobe_n,
    input byte_enables_n, nows_n, data_path_select_n, transfer_direction,
    input cycle_strobe_n, ready_return_n, local_bus_mode_select_n, data_bus,
    output local_device_claim_n, beat_hold, dev_data, dev_data_oe
  );

  modport board (
    output host_side_clock, io_address, addr_a1, aen, address_strobe_n,
    output byte_enables_n, nows_n, data_path_select_n, transfer_direction,
    output cycle_strobe_n, ready_return_n, local_bus_mode_select_n,
    output board_data, board_data_oe,
    input local_device_claim_n, beat_hold, data_bus
  );

endinterface

// File: verilog/esdg_device.sv
// Purpose: Slot-side glue: I/O claim decode and DMA burst data path.
// Assumes: Link pins change only away from host_side_clock rising edges.
// Notes: Two gray-pointer FIFOs carry burst words between link and clk.
// Functional notes
// - Claim only on address match with AEN low
// - Claim output always driven both levels
// - Board ends optional nows at strobe rise
// - Compressed half-period strobes must be accepted
// - Burst beats clocked by the link clock
// - DMA acknowledge selects data path directly
// - Direction high writes device, low reads
// - Cycle strobe qualifies burst write capture
// - Ready return decides or postpones next beat
// - Upper byte enables override address bit one
// - Byte enables captured at address strobe rise

////////////////////////////////////////////////////////////////////////////////
module esdg_afifo
  import esdg_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic in_clk,
  input wire logic out_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic [$clog2(DEPTH):0] in_level,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] out_level
);
  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] esdg_ptr_type;
  localparam esdg_ptr_type FULL_LEVEL = esdg_ptr_type'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    esdg_ptr_type bin;
    esdg_ptr_type gray;
    esdg_ptr_type sync1;
    esdg_ptr_type sync2;
    esdg_ptr_type level;
    logic ready;
  } esdg_fin_type;

  typedef struct packed {
    esdg_ptr_type bin;
    esdg_ptr_type gray;
    esdg_ptr_type sync1;
    esdg_ptr_type sync2;
    esdg_ptr_type level;
    logic valid;
  } esdg_fout_type;

  esdg_fin_type fin, next_fin;
  esdg_fout_type fout, next_fout;

  function automatic esdg_ptr_type to_gray(input esdg_ptr_type b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic esdg_ptr_type to_bin(input esdg_ptr_type g);
    esdg_ptr_type b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    to_bin = b;
  endfunction

  // Fill side: level counts against a lagging read pointer, so it is safe
  always_comb begin
    next_fin = fin;
    if (in_valid && fin.ready) begin
      next_fin.mem[fin.bin[AW-1:0]] = in_data;
      next_fin.bin = fin.bin + esdg_ptr_type'(1);
    end
    next_fin.gray = to_gray(next_fin.bin);
    next_fin.sync1 = fout.gray;
    next_fin.sync2 = fin.sync1;
    next_fin.level = next_fin.bin - to_bin(fin.sync2);
    next_fin.ready = next_fin.level != FULL_LEVEL;
  end

  always_ff @(posedge in_clk or negedge rst_n) begin
    if (!rst_n) begin
      fin <= '0;
      fin.ready <= 1'b1;
    end else begin
      fin <= next_fin;
    end
  end

  always_comb begin
    next_fout = fout;
    if (out_ready && fout.valid) begin
      next_fout.bin = fout.bin + esdg_ptr_type'(1);
    end
    next_fout.gray = to_gray(next_fout.bin);
    next_fout.sync1 = fin.gray;
    next_fout.sync2 = fout.sync1;
    next_fout.level = to_bin(fout.sync2) - next_fout.bin;
    next_fout.valid = next_fout.level != '0;
  end

  always_ff @(posedge out_clk or negedge rst_n) begin
    if (!rst_n) begin
      fout <= '0;
    end else begin
      fout <= next_fout;
    end
  end

  assign in_ready = fin.ready;
  assign in_level = fin.level;
  assign out_valid = fout.valid;
  assign out_data = fin.mem[fout.bin[AW-1:0]];
  assign out_level = fout.level;
endmodule

////////////////////////////////////////////////////////////////////////////////
module esdg_device
  import esdg_pkg::*;
#(
  parameter logic [ADDR_W-1:0] IO_BASE = IO_BASE_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  esdg_if.device link,
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  output logic [BE_W-1:0] rx_lanes,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_data,
  output logic tx_ready
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [LW-1:0] LVL_FULL = LW'(FIFO_DEPTH);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic aen;
    logic [BE_W-1:0] be_n;
    logic claim_n;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic hold;
  } esdg_link_type;

  typedef struct packed {
    logic valid;
    logic [BE_W-1:0] lanes;
    logic [DATA_W-1:0] data;
  } esdg_user_type;

  esdg_link_type lq, next_lq;
  esdg_user_type uq, next_uq;

  logic sel, rd_beat, wr_beat;
  logic wf_in_ready, wf_out_valid, wf_take;
  logic [FIFO_W-1:0] wf_out_data;
  logic [LW-1:0] wf_in_level, rf_out_level, rf_in_level_unused;
  logic [LW-1:0] wf_out_level_unused;
  logic rf_out_valid;
  logic [DATA_W-1:0] rf_out_data;

  // Words written by the bus toward the user side
  esdg_afifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .in_clk(link.host_side_clock),
    .out_clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_beat),
    .in_ready(wf_in_ready),
    .in_data({be_lanes(lq.be_n), link.data_bus}),
    .in_level(wf_in_level),
    .out_valid(wf_out_valid),
    .out_ready(wf_take),
    .out_data(wf_out_data),
    .out_level(wf_out_level_unused)
  );

  // Words the user offers for bus reads
  esdg_afifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .in_clk(clk),
    .out_clk(link.host_side_clock),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .in_level(rf_in_level_unused),
    .out_valid(rf_out_valid),
    .out_ready(rd_beat),
    .out_data(rf_out_data),
    .out_level(rf_out_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Link side: every decision is taken on a rising link clock edge, so a
  // half-period command strobe needs no minimum width here
  always_comb begin
    next_lq = lq;
    // Transparent while the strobe is low, held from its rise
    if (!link.address_strobe_n) begin
      next_lq.addr = link.io_address;
      next_lq.aen = link.aen;
      next_lq.be_n = link.byte_enables_n;
    end
    // Bit one of the address is never looked at
    next_lq.claim_n = !(link.local_bus_mode_select_n
                        && next_lq.addr == IO_BASE
                        && !next_lq.aen);
    next_lq.data_oe = sel && !link.transfer_direction;
    if (rd_beat) begin
      next_lq.data_out = rf_out_data;
    end
    // Hold looks one beat ahead because the board reacts half a period late
    if (link.transfer_direction) begin
      next_lq.hold = (wf_in_level + LW'(wr_beat)) >= LVL_FULL;
    end else begin
      next_lq.hold = rf_out_level <= LW'(rd_beat);
    end
  end

  // Acknowledge with mode select high selects the path, no address involved
  assign sel = !link.data_path_select_n && link.local_bus_mode_select_n;
  assign rd_beat = sel && !link.transfer_direction
                   && !link.ready_return_n && rf_out_valid;
  assign wr_beat = sel && link.transfer_direction && !link.cycle_strobe_n
                   && !link.ready_return_n && wf_in_ready;

  always_ff @(posedge link.host_side_clock or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
      lq.claim_n <= 1'b1;
      lq.be_n <= BE_DWORD;
      lq.aen <= 1'b1;
      lq.hold <= 1'b1;
    end else begin
      lq <= next_lq;
    end
  end

  // Push-pull: the claim is a plain output with no enable
  assign link.local_device_claim_n = lq.claim_n;
  assign link.dev_data = lq.data_out;
  assign link.dev_data_oe = lq.data_oe;
  assign link.beat_hold = lq.hold;

  //////////////////////////////////////////////////////////////////////////////
  // User side: one output register so rx pins come from flops
  assign wf_take = wf_out_valid && (!uq.valid || rx_ready);

  always_comb begin
    next_uq = uq;
    if (wf_take) begin
      next_uq.valid = 1'b1;
      next_uq.lanes = wf_out_data[FIFO_W-1:DATA_W];
      next_uq.data = wf_out_data[DATA_W-1:0];
    end else if (rx_ready) begin
      next_uq.valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uq <= '0;
    end else begin
      uq <= next_uq;
    end
  end

  assign rx_valid = uq.valid;
  assign rx_lanes = uq.lanes;
  assign rx_data = uq.data;
endmodule

// File: verilog/esdg_board.sv
// Purpose: System board end: link clock, probe cycles and DMA bursts.
// Assumes: Single clk domain; link clock is divided down from clk.
// Notes: Strobe, acknowledge, direction, cycle, ready and data outputs change only on the falling link clock edge.
module esdg_board
  import esdg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  esdg_if.board link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [BE_W-1:0] cmd_be_n,
  input wire logic [LEN_W-1:0] cmd_len,
  output logic cmd_ready,
  input wire logic wr_valid,
  input wire logic [DATA_W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic rsp_valid,
  output logic rsp_claimed,
  output logic rsp_compressed,
  output logic done
);
  localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(BCLK_HALF_CLKS - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LAUNCH = 3'h1,
    ST_ADDR = 3'h2,
    ST_CMD = 3'h3,
    ST_BURST = 3'h4
  } esdg_state_type;

  typedef struct packed {
    esdg_state_type state;
    logic [DIV_W-1:0] div;
    logic bclk;
    logic [1:0] kind;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be_n;
    logic aen;
    logic strobe_n;
    logic dak_n;
    logic dir;
    logic cyc_n;
    logic ready_n;
    logic nows_n;
    logic compressed;
    logic [1:0] ticks;
    logic [LEN_W-1:0] remaining;
    logic capture;
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic rsp_valid;
    logic rsp_claimed;
    logic done;
  } esdg_board_type;

  esdg_board_type q, next_q;
  logic tick, fall;

  assign tick = q.div == '0;
  assign fall = tick && q.bclk;

  always_comb begin
    next_q = q;
    next_q.wr_ready = 1'b0;
    next_q.rd_valid = 1'b0;
    next_q.rsp_valid = 1'b0;
    next_q.done = 1'b0;
    next_q.div = tick ? DIV_LOAD : q.div - DIV_W'(1);
    if (tick) begin
      next_q.bclk = !q.bclk;
    end
    // Follows the claim, but is gone once the strobe rises
    next_q.nows_n = !(!q.strobe_n && !link.local_device_claim_n);
    case (q.state)
      ST_IDLE: begin
        next_q.cmd_ready = 1'b1;
        if (cmd_valid && q.cmd_ready) begin
          next_q.cmd_ready = 1'b0;
          next_q.kind = cmd_kind;
          next_q.addr = cmd_addr;
          next_q.be_n = cmd_be_n;
          next_q.remaining = cmd_len;
          next_q.state = ST_LAUNCH;
        end
      end
      ST_LAUNCH: begin
        if (fall) begin
          next_q.strobe_n = 1'b0;
          next_q.state = ST_ADDR;
          if (q.kind == CMD_PROBE) begin
            next_q.aen = 1'b0;
          end else begin
            next_q.dak_n = 1'b0;
            next_q.dir = q.kind == CMD_DMA_WRITE;
            next_q.cyc_n = q.kind != CMD_DMA_WRITE;
          end
        end
      end
      ST_ADDR: begin
        if (fall) begin
          next_q.strobe_n = 1'b1;
          if (q.kind == CMD_PROBE) begin
            next_q.compressed = !q.nows_n;
            next_q.ticks = q.nows_n ? CMD_TICKS_NORMAL : CMD_TICKS_COMP;
            next_q.state = ST_CMD;
          end else begin
            next_q.state = ST_BURST;
          end
        end
      end
      ST_CMD: begin
        if (tick) begin
          next_q.ticks = q.ticks - 2'h1;
          if (q.ticks == 2'h1) begin
            next_q.rsp_valid = 1'b1;
            next_q.rsp_claimed = !link.local_device_claim_n;
            next_q.aen = 1'b1;
            next_q.state = ST_IDLE;
          end
        end
      end
      ST_BURST: begin
        if (fall) begin
          if (q.capture && !q.dir) begin
            next_q.rd_valid = 1'b1;
            next_q.rd_data = link.data_bus;
          end
          next_q.capture = 1'b0;
          next_q.ready_n = 1'b1;
          // One beat per link clock, offered only while not held
          if (q.remaining != '0 && !link.beat_hold
              && (!q.dir || wr_valid)) begin
            next_q.ready_n = 1'b0;
            next_q.remaining = q.remaining - LEN_W'(1);
            next_q.capture = 1'b1;
            if (q.dir) begin
              next_q.data = wr_data;
              next_q.data_oe = 1'b1;
              next_q.wr_ready = 1'b1;
            end
          end else if (q.remaining == '0 && !q.capture) begin
            next_q.dak_n = 1'b1;
            next_q.cyc_n = 1'b1;
            next_q.dir = 1'b0;
            next_q.data_oe = 1'b0;
            next_q.done = 1'b1;
            next_q.state = ST_IDLE;
          end
        end
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.aen <= 1'b1;
      q.strobe_n <= 1'b1;
      q.dak_n <= 1'b1;
      q.cyc_n <= 1'b1;
      q.ready_n <= 1'b1;
      q.nows_n <= 1'b1;
      q.be_n <= BE_DWORD;
    end else begin
      q <= next_q;
    end
  end

  assign link.host_side_clock = q.bclk;
  assign link.io_address = q.addr;
  assign link.addr_a1 = 1'b0;
  assign link.local_bus_mode_select_n = 1'b1;
  assign link.aen = q.aen;
  assign link.address_strobe_n = q.strobe_n;
  assign link.byte_enables_n = q.be_n;
  assign link.nows_n = q.nows_n;
  assign link.data_path_select_n = q.dak_n;
  assign link.transfer_direction = q.dir;
  assign link.cycle_strobe_n = q.cyc_n;
  assign link.ready_return_n = q.ready_n;
  assign link.board_data = q.data;
  assign link.board_data_oe = q.data_oe;

  assign cmd_ready = q.cmd_ready;
  assign wr_ready = q.wr_ready;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rd_data;
  assign rsp_valid = q.rsp_valid;
  assign rsp_claimed = q.rsp_claimed;
  assign rsp_compressed = q.compressed;
  assign done = q.done;
endmodule

// File: verif/esdg_sva.sv
// Purpose: Link-side checker for the glue device and its system board end.
// Assumes: Both ends share rst_n; all link signals sampled on link clock.
// Notes: Claim timing follows the one-edge update of the device decode.
module esdg_sva
  import esdg_pkg::*;
#(
  parameter logic [ADDR_W-1:0] IO_BASE = IO_BASE_DEFAULT
) (
  input wire logic host_side_clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] io_address,
  input wire logic addr_a1,
  input wire logic aen,
  input wire logic address_strobe_n,
  input wire logic local_device_claim_n,
  input wire logic data_path_select_n,
  input wire logic transfer_direction,
  input wire logic cycle_strobe_n,
  input wire logic ready_return_n,
  input wire logic beat_hold,
  input wire logic local_bus_mode_select_n,
  input wire logic board_data_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge host_side_clock);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  a_claim_on_match: assert property (
    !address_strobe_n && !aen && io_address == IO_BASE
    && local_bus_mode_select_n |=> !local_device_claim_n)
    else $error("claim not raised on matching decode");
  a_claim_no_match: assert property (
    !address_strobe_n && (aen || io_address != IO_BASE)
    |=> local_device_claim_n)
    else $error("claim raised without a valid decode");
  a_claim_cause: assert property (
    $fell(local_device_claim_n) |-> $past(!aen && io_address == IO_BASE))
    else $error("claim fell with no matching address");
  a_read_drives_bus: assert property (
    !data_path_select_n && !transfer_direction |=> dev_data_oe)
    else $error("device not driving data during DMA read");
  a_write_bus_free: assert property (
    transfer_direction || data_path_select_n |=> !dev_data_oe)
    else $error("device drives data outside DMA read");
  a_no_contention: assert property (
    !(dev_data_oe && board_data_oe))
    else $error("both ends drive the data bus");
  a_write_has_cycle: assert property (
    !ready_return_n && transfer_direction && !data_path_select_n
    |-> !cycle_strobe_n)
    else $error("write beat without cycle strobe");
  a_beat_obeys_hold: assert property (
    !ready_return_n |-> !beat_hold)
    else $error("beat ran while device held it off");
  a_mode_pins_tied: assert property (
    local_bus_mode_select_n && !addr_a1)
    else $error("mode select or address bit one not tied");

  c_claim: cover property ($fell(local_device_claim_n));
  c_write_beat: cover property (!ready_return_n && !cycle_strobe_n);
  c_read_beat: cover property (!ready_return_n && dev_data_oe);
  c_hold: cover property ($rose(beat_hold) ##1 beat_hold);
endmodule

// File: verif/tb_eisa_slave_dma_burst_glue.sv
// Purpose: Both ends joined at the slot; user sides driven and scored.
// Assumes: Board makes the link clock from clk by its own divider.
// Notes: Expected words queue up at drive time and a monitor pops them.
module tb_eisa_slave_dma_burst_glue;
  import esdg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, rx_ready, tx_valid, tx_ready, rx_valid, cmd_valid;
  logic cmd_ready, wr_valid, wr_ready, rd_valid, rsp_valid, rsp_claimed;
  logic rsp_compressed, done;
  logic [DATA_W-1:0] rx_data, tx_data, wr_data, rd_data;
  logic [BE_W-1:0] rx_lanes, cmd_be_n;
  logic [1:0] cmd_kind;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LEN_W-1:0] cmd_len;
  int errors, checks_done, cycles;
  bit rx_stall;
  logic [35:0] exp_rx[$];
  logic [35:0] exp_rd[$];
  logic [35:0] exp_rsp[$];
  logic [BE_W-1:0] be_tab[8] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7,
                                 4'h5};
  logic [ADDR_W-1:0] addr_tab[4] = '{12'h030, 12'h031, 12'h830, 12'h000};

  esdg_if esdg_if_i ();
  esdg_device esdg_device_i (.clk(clk), .rst_n(rst_n), .link(esdg_if_i),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_lanes(rx_lanes),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  esdg_board esdg_board_i (.clk(clk), .rst_n(rst_n), .link(esdg_if_i),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_be_n(cmd_be_n), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .rsp_valid(rsp_valid),
    .rsp_claimed(rsp_claimed), .rsp_compressed(rsp_compressed),
    .done(done));
  esdg_sva esdg_sva_i (.host_side_clock(esdg_if_i.host_side_clock),
    .rst_n(rst_n), .io_address(esdg_if_i.io_address),
    .addr_a1(esdg_if_i.addr_a1), .aen(esdg_if_i.aen),
    .address_strobe_n(esdg_if_i.address_strobe_n),
    .local_device_claim_n(esdg_if_i.local_device_claim_n),
    .data_path_select_n(esdg_if_i.data_path_select_n),
    .transfer_direction(esdg_if_i.transfer_direction),
    .cycle_strobe_n(esdg_if_i.cycle_strobe_n),
    .ready_return_n(esdg_if_i.ready_return_n),
    .beat_hold(esdg_if_i.beat_hold),
    .local_bus_mode_select_n(esdg_if_i.local_bus_mode_select_n),
    .board_data_oe(esdg_if_i.board_data_oe),
    .dev_data_oe(esdg_if_i.dev_data_oe));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Unsupported enable patterns must reach the user side with no lanes
  function automatic logic [BE_W-1:0] lanes_of(input logic [BE_W-1:0] be);
    case (be)
      4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7: lanes_of = ~be;
      default: lanes_of = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      results();
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      check({rx_lanes, rx_data}, exp_rx.pop_front());
    if (rd_valid === 1'b1)
      check(36'(rd_data), exp_rd.pop_front());
    // A claimed probe raises nows, so its command phase is compressed
    if (rsp_valid === 1'b1)
      check(36'({rsp_compressed, rsp_claimed}), exp_rsp.pop_front());
  end

  always @(posedge clk)
    rx_ready <= !rx_stall && ($urandom_range(3) != 0);

  task automatic send_cmd(input logic [1:0] k, input logic [ADDR_W-1:0] a,
                          input logic [BE_W-1:0] be, input int n);
    int t;
    t = 0;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_be_n <= be;
    cmd_len <= LEN_W'(n);
    cmd_valid <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (cmd_ready !== 1'b1 && t < 200);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      t++;
    end while (done !== 1'b1 && rsp_valid !== 1'b1 && t < 8000);
    if (t >= 8000)
      check(36'h0, 36'h1);
  endtask

  task automatic feed(input logic [BE_W-1:0] be, input int n);
    int t;
    logic [DATA_W-1:0] w;
    for (int i = 0; i < n; i++) begin
      w = $urandom();
      exp_rx.push_back({lanes_of(be), w});
      wr_data <= w;
      wr_valid <= 1'b1;
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (wr_ready !== 1'b1 && t < 8000);
    end
    wr_valid <= 1'b0;
  endtask

  task automatic burst_wr(input logic [BE_W-1:0] be, input int n);
    fork
      send_cmd(CMD_DMA_WRITE, IO_BASE_DEFAULT, be, n);
      feed(be, n);
    join
  endtask

  task automatic fill_tx(input int n);
    logic [DATA_W-1:0] w;
    for (int i = 0; i < n; i++) begin
      w = $urandom();
      exp_rd.push_back(36'(w));
      tx_data <= w;
      tx_valid <= 1'b1;
      do @(posedge clk); while (tx_ready !== 1'b1 && cycles < 29000);
    end
    tx_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    rx_stall = 1'b0;
    tx_valid = 1'b0;
    tx_data = '0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_PROBE;
    cmd_addr = '0;
    cmd_be_n = BE_DWORD;
    cmd_len = '0;
    wr_valid = 1'b0;
    wr_data = '0;
    void'($urandom(14));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (addr_tab[i]) begin
      exp_rsp.push_back(36'({2{addr_tab[i] == IO_BASE_DEFAULT}}));
      send_cmd(CMD_PROBE, addr_tab[i], BE_DWORD, 0);
    end
    foreach (be_tab[i])
      burst_wr(be_tab[i], 3);
    // Stalled user side: device must hold off the board until it drains
    rx_stall <= 1'b1;
    fork
      burst_wr(BE_DWORD, 20);
      begin
        repeat (400) @(posedge clk);
        check(36'(esdg_if_i.beat_hold), 36'h1);
        rx_stall <= 1'b0;
      end
    join
    fill_tx(16);
    repeat (4) @(posedge clk);
    check(36'(tx_ready), 36'h0);
    send_cmd(CMD_DMA_READ, IO_BASE_DEFAULT, BE_DWORD, 16);
    repeat (60) @(posedge clk);
    check(36'(exp_rx.size() + exp_rd.size() + exp_rsp.size()), 36'h0);
    results();
  end
endmodule
